// file: src/flash_id_pkg.sv
// Constants and types for the serial flash ID, reset and write-permit commands
// How it works
// - 9F shifts out maker, type and part bytes
// - Full ID read not decoded while busy
// - Chip select rise returns to standby
// - AB plus three dummies gives signature byte
// - Signature byte repeats while host keeps clocking
// - 90 plus address picks maker or part first
// - B1 enters OTP window, C1 leaves it
// - 2F sets sticky lock bit, clears permit
// - Soft reset needs 66 then 99
// - Any other command between disarms soft reset
// - Opcode 06 sets the write-permit latch
// - Opcode 04 clears the write-permit latch
// - Upper I/O lanes ignored for these commands
// - Permit cleared on reset, writes, suspend, clear
// - ID bits leave on falling clock, MSB first
// - Full ID data starts next falling edge
package flash_id_pkg;

  // Opcodes
  localparam logic [7:0] OP_FULL_ID   = 8'h9f;
  localparam logic [7:0] OP_SIGNATURE = 8'hab;
  localparam logic [7:0] OP_PAIR_ID   = 8'h90;
  localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
  localparam logic [7:0] OP_OTP_LEAVE = 8'hc1;
  localparam logic [7:0] OP_LOCK      = 8'h2f;
  localparam logic [7:0] OP_IDLE      = 8'h00;
  localparam logic [7:0] OP_RST_ARM   = 8'h66;
  localparam logic [7:0] OP_RST_FIRE  = 8'h99;
  localparam logic [7:0] OP_WP_SET    = 8'h06;
  localparam logic [7:0] OP_WP_CLEAR  = 8'h04;

  // Frame bit positions
  localparam logic [5:0] OP_LAST_BIT  = 6'h07;   // Edge count before 8th edge
  localparam logic [5:0] OP_BITS      = 6'h08;   // Opcode length
  localparam logic [5:0] ADDR_LAST    = 6'h1f;   // Edge count before 32nd edge
  localparam logic [5:0] PREFIX_BITS  = 6'h20;   // Opcode plus three bytes

  // Identifier lengths in bits
  localparam logic [4:0] LEN_FULL     = 5'h18;
  localparam logic [4:0] LEN_PAIR     = 5'h10;
  localparam logic [4:0] LEN_SIG      = 5'h08;
  localparam logic [4:0] LEN_ONE      = 5'h01;

  // Readout modes
  typedef enum logic [1:0] {
    RM_NONE,
    RM_FULL,
    RM_SIG,
    RM_PAIR
  } read_mode_t;

  // Command frame handed from link to system clock
  typedef struct packed {
    logic [7:0] op;       // Opcode byte
    logic       exact;    // Frame ended after exactly eight clocks
  } frame_t;

endpackage

// file: src/flash_id_cmds.sv
// Serial flash ID, OTP window, soft reset and write-permit command block
`timescale 1ns/10ps
`default_nettype none
module flash_id_cmds
  import flash_id_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] TYPE_ID  = 8'h3c,  // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h11   // Arbitrary value
) (
  input  wire logic i_clk,          // System clock, 10 MHz
  input  wire logic i_reset_n,      // Async reset, active low
  input  wire logic i_sclk,         // Serial clock from host
  input  wire logic i_cs_n,         // Chip select, active low
  input  wire logic i_io_lane0,     // Serial data in
  input  wire logic i_busy,         // Program or erase running
  input  wire logic i_wp_clear,     // Write done or suspend pulse
  output logic      o_so,           // Serial data out
  output logic      o_so_oe,        // Serial data out enable
  output logic      o_write_permit, // Write-permit latch
  output logic      o_otp_mode,     // OTP window active
  output logic      o_lock_down,    // Security lock bit
  output logic      o_reset_armed,  // Soft reset armed
  output logic      o_soft_reset    // Soft reset pulse
);

  //////////////////////////////////////////////////////////////////////////
  // Link domain, serial clock

  // Counter, shift, mode and output logic clear whenever select is high
  wire        link_rst_n = i_reset_n & ~i_cs_n;

  logic [5:0] cnt_ff;       // Rising edges in frame, saturating
  logic [6:0] sh_ff;        // Incoming opcode bits
  logic       addr_lsb_ff;  // Address byte bit 0
  read_mode_t mode_ff;      // Active readout
  logic       busy_s1_ff;   // Busy synchroniser, first
  logic       busy_s2_ff;   // Busy synchroniser, second
  frame_t     frame_ff;     // Last decoded frame
  logic       tgl_ff;       // Opcode-seen event toggle
  logic [4:0] ptr_ff;       // Output bit pointer
  logic       so_ff;        // Output bit
  logic       oe_ff;        // Output enable

  // Opcode as completed at the eighth rising edge
  wire [7:0]  op_now    = {sh_ff, i_io_lane0};
  wire        at_op     = (cnt_ff == OP_LAST_BIT);
  wire        at_addr   = (cnt_ff == ADDR_LAST);
  wire [5:0]  nxt_cnt   = (cnt_ff == PREFIX_BITS) ? cnt_ff : cnt_ff + 6'h01;

  // Readout chosen from the opcode
  read_mode_t nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    if (at_op) begin
      case (op_now)
        OP_FULL_ID:   nxt_mode = busy_s2_ff ? RM_NONE : RM_FULL;
        OP_SIGNATURE: nxt_mode = RM_SIG;
        OP_PAIR_ID:   nxt_mode = RM_PAIR;
        default:      nxt_mode = RM_NONE;
      endcase
    end
  end

  // Frame counter, opcode shift, mode
  always_ff @(posedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_ff      <= 6'h00;
      sh_ff       <= 7'h00;
      addr_lsb_ff <= 1'b0;
      mode_ff     <= RM_NONE;
    end else begin
      cnt_ff      <= nxt_cnt;
      sh_ff       <= op_now[6:0];
      addr_lsb_ff <= at_addr ? i_io_lane0 : addr_lsb_ff;
      mode_ff     <= nxt_mode;
    end
  end

  // Busy level into the link domain
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end else begin
      busy_s1_ff <= i_busy;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  // Frame record survives select rise for the system side
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_ff <= '0;
      tgl_ff   <= 1'b0;
    end else if (!i_cs_n && at_op) begin
      frame_ff <= '{op: op_now, exact: 1'b1};
      tgl_ff   <= ~tgl_ff;
    end else if (!i_cs_n && cnt_ff == OP_BITS) begin
      frame_ff.exact <= 1'b0;   // Ninth clock: not single byte
    end
  end

  // Identifier selection
  wire        data_on = (mode_ff == RM_FULL && cnt_ff >= OP_BITS) ||
                        (mode_ff != RM_NONE && cnt_ff == PREFIX_BITS);
  wire [4:0]  id_len  = (mode_ff == RM_FULL) ? LEN_FULL :
                        (mode_ff == RM_PAIR) ? LEN_PAIR : LEN_SIG;
  wire [23:0] id_vec  = (mode_ff == RM_FULL) ? {MAKER_ID, TYPE_ID, PART_ID} :
                        (mode_ff != RM_PAIR) ? {16'h0000, PART_ID} :
                        addr_lsb_ff ? {8'h00, PART_ID, MAKER_ID} :
                                      {8'h00, MAKER_ID, PART_ID};
  wire [4:0]  id_last = id_len - LEN_ONE;
  wire [4:0]  id_idx  = id_last - ptr_ff;
  wire [4:0]  nxt_ptr = (ptr_ff == id_last) ? 5'h00 : ptr_ff + LEN_ONE;

  // Output shifts on falling edges, MSB first
  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ptr_ff <= 5'h00;
      so_ff  <= 1'b0;
      oe_ff  <= 1'b0;           // Released at select rise
    end else if (data_on) begin
      ptr_ff <= nxt_ptr;
      so_ff  <= id_vec[id_idx];
      oe_ff  <= 1'b1;
    end
  end

  assign o_so    = so_ff;
  assign o_so_oe = oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock

  logic   cs_s1_ff;    // Select synchroniser, first
  logic   cs_s2_ff;    // Select synchroniser, second
  logic   cs_s3_ff;    // Select edge history
  logic   tg_s1_ff;    // Toggle synchroniser, first
  logic   tg_s2_ff;    // Toggle synchroniser, second
  logic   tg_s3_ff;    // Toggle edge history
  frame_t fr_s1_ff;    // Frame, first stage
  frame_t fr_s2_ff;    // Frame, second stage
  logic   pend_ff;     // Opcode seen in current frame

  // Synchronisers; frame is static while select is high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_s3_ff <= 1'b0;
      fr_s1_ff <= '0;
      fr_s2_ff <= '0;
    end else begin
      cs_s1_ff <= i_cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      tg_s1_ff <= tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
      fr_s1_ff <= frame_ff;
      fr_s2_ff <= fr_s1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command completion and latches

  logic   wel_ff;      // Write-permit latch
  logic   otp_ff;      // OTP window
  logic   lock_ff;     // Lock-down bit
  logic   armed_ff;    // Soft reset armed
  logic   srst_ff;     // Soft reset pulse

  wire cs_rise   = cs_s2_ff & ~cs_s3_ff;
  wire op_event  = tg_s2_ff ^ tg_s3_ff;
  wire cmd_done  = cs_rise & (pend_ff | op_event);
  wire single    = cmd_done & fr_s2_ff.exact;
  wire [7:0] op  = fr_s2_ff.op;

  // Single-byte command decodes
  wire wp_set_go = single & (op == OP_WP_SET);
  wire wp_clr_go = single & (op == OP_WP_CLEAR);
  wire enter_go  = single & (op == OP_OTP_ENTER);
  wire leave_go  = single & (op == OP_OTP_LEAVE);
  wire lock_go   = single & (op == OP_LOCK);
  wire arm_go    = single & (op == OP_RST_ARM);
  wire fire_go   = single & (op == OP_RST_FIRE) & armed_ff;

  // Any finished command rearms or disarms; idle opcode only disarms
  wire nxt_armed = cmd_done ? arm_go : armed_ff;
  wire nxt_pend  = cs_rise ? 1'b0 : (pend_ff | op_event);
  // Set wins over an external clear in the same cycle
  wire nxt_wel   = wp_set_go ? 1'b1 :
                   (wp_clr_go | lock_go | fire_go | i_wp_clear) ? 1'b0 : wel_ff;
  wire nxt_otp   = enter_go ? 1'b1 : (leave_go | fire_go) ? 1'b0 : otp_ff;
  wire nxt_lock  = lock_ff | lock_go;

  // Latch state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_ff  <= 1'b0;
      wel_ff   <= 1'b0;         // Power-up clear
      otp_ff   <= 1'b0;
      lock_ff  <= 1'b0;
      armed_ff <= 1'b0;
      srst_ff  <= 1'b0;
    end else begin
      pend_ff  <= nxt_pend;
      wel_ff   <= nxt_wel;
      otp_ff   <= nxt_otp;
      lock_ff  <= nxt_lock;
      armed_ff <= nxt_armed;
      srst_ff  <= fire_go;
    end
  end

  assign o_write_permit = wel_ff;
  assign o_otp_mode     = otp_ff;
  assign o_lock_down    = lock_ff;
  assign o_reset_armed  = armed_ff;
  assign o_soft_reset   = srst_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Permit set lands one cycle after a lone set opcode
  property p_wel_set;
    @(posedge i_clk) disable iff (!i_reset_n)
      wp_set_go |=> wel_ff && cs_s3_ff;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("permit not set");

  // Clear opcode drops the latch
  property p_wel_clr;
    @(posedge i_clk) disable iff (!i_reset_n)
      wp_clr_go |=> !wel_ff;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("permit not cleared");

  // Lock bit never falls once set
  property p_lock_sticky;
    @(posedge i_clk) disable iff (!i_reset_n)
      lock_ff |=> lock_ff [*8];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock fell");

  // Lock command ends with permit clear and lock set
  property p_lock_wel;
    @(posedge i_clk) disable iff (!i_reset_n)
      lock_go |=> (!wel_ff && lock_ff);
  endproperty
  a_lock_wel: assert property (p_lock_wel) else $error("lock left permit");

  // Soft reset only right after an armed frame
  property p_fire_order;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(srst_ff) |-> $past(armed_ff) && !armed_ff && !wel_ff;
  endproperty
  a_fire_order: assert property (p_fire_order) else $error("reset out of order");

  // Other finished command disarms
  property p_disarm;
    @(posedge i_clk) disable iff (!i_reset_n)
      (cmd_done && !arm_go) |=> !armed_ff ##1 !srst_ff;
  endproperty
  a_disarm: assert property (p_disarm) else $error("still armed");

  // External clear empties the latch unless a set coincides
  property p_ext_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_wp_clear && !wp_set_go) |=> !wel_ff;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("permit kept");

  // No drive while select is high
  property p_oe_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_cs_n |-> !o_so_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while deselected");

  // Full ID never starts while busy was seen
  property p_busy_gate;
    @(posedge i_sclk) disable iff (!link_rst_n)
      (at_op && busy_s2_ff && op_now == OP_FULL_ID) |=> mode_ff == RM_NONE;
  endproperty
  a_busy_gate: assert property (p_busy_gate) else $error("ID decoded while busy");

  // OTP enter sets window next cycle
  property p_otp;
    @(posedge i_clk) disable iff (!i_reset_n)
      enter_go |=> otp_ff;
  endproperty
  a_otp: assert property (p_otp) else $error("OTP not entered");

  // Full ID enable and maker MSB stand by the ninth rising edge
  property p_full_msb;
    @(posedge i_sclk) disable iff (!link_rst_n)
      (mode_ff == RM_FULL && cnt_ff == OP_BITS) |-> (o_so_oe && o_so == MAKER_ID[7]);
  endproperty
  a_full_msb: assert property (p_full_msb) else $error("full ID late");

  // Second maker bit follows on the next fall, MSB first
  property p_full_next;
    @(posedge i_sclk) disable iff (!link_rst_n)
      (mode_ff == RM_FULL && cnt_ff == OP_BITS + 6'h01) |-> o_so == MAKER_ID[6];
  endproperty
  a_full_next: assert property (p_full_next) else $error("full ID bit order");

  // Signature wraps to its MSB after its last bit
  property p_sig_repeat;
    @(posedge i_sclk) disable iff (!link_rst_n)
      (mode_ff == RM_SIG && cnt_ff == PREFIX_BITS && ptr_ff == 5'h00)
        |-> o_so == PART_ID[0] ##1 o_so == PART_ID[7];
  endproperty
  a_sig_repeat: assert property (p_sig_repeat) else $error("signature not repeated");

  // Address bit 0 picks which byte leads the pair readout
  property p_pair_order;
    @(posedge i_sclk) disable iff (!link_rst_n)
      (mode_ff == RM_PAIR && cnt_ff == PREFIX_BITS && ptr_ff == 5'h02)
        |-> o_so == (addr_lsb_ff ? PART_ID[6] : MAKER_ID[6]);
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("pair order wrong");

  // Idle opcode leaves latches alone and only disarms
  property p_idle_noop;
    @(posedge i_clk) disable iff (!i_reset_n)
      (single && op == OP_IDLE && !i_wp_clear)
        |=> $stable(wel_ff) && $stable(otp_ff) && $stable(lock_ff) && !armed_ff;
  endproperty
  a_idle_noop: assert property (p_idle_noop) else $error("idle changed state");

  // Frames other than exactly one byte change no latch
  property p_not_single;
    @(posedge i_clk) disable iff (!i_reset_n)
      (cmd_done && !fr_s2_ff.exact && !i_wp_clear)
        |=> $stable(wel_ff) && $stable(otp_ff) && $stable(lock_ff) && !srst_ff;
  endproperty
  a_not_single: assert property (p_not_single) else $error("long frame acted");

endmodule
`default_nettype wire

// file: testbench/spi_host_model.sv
// Host side of the serial link: frames commands and collects answers
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic      o_sclk,  // Serial clock, low outside frames
  output logic      o_cs_n,  // Chip select, active low
  output logic      o_mosi,  // Serial data to device
  input  wire logic i_so,    // Serial data from device
  input  wire logic i_so_oe  // Device drives serial data
);
  logic [47:0] rx_bits;  // Bits read after the command
  logic        oe_all;   // Enable high on every read bit
  logic        oe_any;   // Enable high on some read bit

  ////////////////////////////////////////////////////////////////////////
  // Idle levels
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: ntx bits from tx MSB first, then nrx bits read
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
    rx_bits = '0;
    oe_all  = 1'b1;
    oe_any  = 1'b0;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) begin
        o_mosi = tx[ntx-1-i];  // Command bits, MSB first
      end else begin
        o_mosi = ~o_mosi;  // Lane is don't care while reading
      end
      #15 o_sclk = 1'b1;
      if (i >= ntx) begin
        rx_bits = {rx_bits[46:0], i_so};
        oe_all  = oe_all & (i_so_oe === 1'b1);
        oe_any  = oe_any | (i_so_oe === 1'b1);
      end
      #15 o_sclk = 1'b0;
    end
    #15 o_cs_n = 1'b1;  // Whole frame, then select high
    o_mosi = ~o_mosi;  // Released lane shows no stale value
    #700;  // Select high over seven system clocks
  endtask
endmodule
`default_nettype wire

// file: testbench/serial_flash_id_reset_wel_cmds_tb.sv
// Self-checking bench for the ID, reset and write-permit command block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_reset_wel_cmds_tb
  import flash_id_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary value
  localparam logic [7:0] KIND  = 8'h3c;  // Arbitrary value
  localparam logic [7:0] PART  = 8'h11;  // Arbitrary value
  logic i_clk, i_reset_n, i_busy, i_wp_clear;  // Bench driven inputs
  logic sclk, cs_n, mosi;                      // Link from host model
  logic so, so_oe, wp, otp, lock, armed, srst; // Device outputs
  int   error_cnt, checks_done, cycles, pulses; // Bench counters
  logic [31:0] rnd;                              // Random dummy bytes

  ////////////////////////////////////////////////////////////////////////
  // Device and host model
  flash_id_cmds #(.MAKER_ID(MAKER), .TYPE_ID(KIND), .PART_ID(PART)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_io_lane0(mosi), .i_busy(i_busy), .i_wp_clear(i_wp_clear), .o_so(so),
    .o_so_oe(so_oe), .o_write_permit(wp), .o_otp_mode(otp), .o_lock_down(lock),
    .o_reset_armed(armed), .o_soft_reset(srst));
  spi_host_model host_u (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_so(so), .i_so_oe(so_oe));

  ////////////////////////////////////////////////////////////////////////
  // Clock, reset pulse count and hang limit
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (srst === 1'b1) pulses++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected pair readout for address bit 0
  function automatic logic [47:0] pair_exp(input logic sel);
    return sel ? {32'h0, PART, MAKER} : {32'h0, MAKER, PART};
  endfunction
  task automatic op(input logic [7:0] code);
    host_u.frame({24'h0, code}, 8, 0);  // Defined opcodes only
  endtask
  task automatic sys(input logic busy, input logic clr);
    @(posedge i_clk);
    #1 i_busy = busy;
    i_wp_clear = clr;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_reset_n  = 1'b0;
    i_busy     = 1'b0;
    i_wp_clear = 1'b0;
    rnd = $urandom(32'hed61);
    repeat (4) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    repeat (2) @(posedge i_clk);
    check("idle outputs", 48'h0, {wp, otp, lock, armed, srst, so_oe});
    host_u.frame({24'h0, OP_FULL_ID}, 8, 48);
    check("full id", {MAKER, KIND, PART, MAKER, KIND, PART}, host_u.rx_bits);
    check("full id enable", 48'h1, host_u.oe_all);
    check("enable after frame", 48'h0, so_oe);
    host_u.frame({24'h0, OP_FULL_ID}, 8, 5);
    check("cut id", {43'h0, MAKER[7:3]}, host_u.rx_bits);
    check("enable after cut", 48'h0, so_oe);
    sys(1'b1, 1'b0);
    repeat (3) @(posedge i_clk);
    host_u.frame({24'h0, OP_FULL_ID}, 8, 8);
    check("busy id enable", 48'h0, host_u.oe_any);
    sys(1'b0, 1'b0);
    rnd = $urandom();
    host_u.frame({OP_SIGNATURE, rnd[23:0]}, 32, 16);
    check("signature", {32'h0, PART, PART}, host_u.rx_bits);
    for (int a = 0; a < 2; a++) begin
      rnd = $urandom();
      host_u.frame({OP_PAIR_ID, rnd[15:0], 8'(a)}, 32, 16);
      check("pair id", pair_exp(a[0]), host_u.rx_bits);
    end
    op(OP_WP_SET);
    check("permit set", 48'h1, wp);
    op(OP_WP_CLEAR);
    check("permit clear", 48'h0, wp);
    host_u.frame({23'h0, OP_WP_SET, 1'b0}, 9, 0);
    check("nine clock set", 48'h0, wp);
    op(OP_WP_SET);
    sys(1'b0, 1'b1);
    sys(1'b0, 1'b0);
    repeat (2) @(posedge i_clk);
    check("permit after done", 48'h0, wp);
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom();
      op(rnd[0] ? OP_WP_SET : OP_WP_CLEAR);
      check("random permit", {47'h0, rnd[0]}, wp);
    end
    op(OP_OTP_ENTER);
    check("otp enter", 48'h1, otp);
    op(OP_OTP_LEAVE);
    check("otp leave", 48'h0, otp);
    op(OP_WP_SET);
    op(OP_LOCK);
    check("lock and permit", 48'h2, {lock, wp});
    op(OP_OTP_ENTER);
    op(OP_WP_SET);
    op(OP_RST_ARM);
    check("armed", 48'h1, armed);
    op(OP_RST_FIRE);
    check("soft reset", {32'h1, 16'h0100}, {pulses, 8'(lock), 8'(wp | otp | armed)});
    op(OP_RST_ARM);
    op(OP_IDLE);
    check("disarm by idle", 48'h0, armed);
    op(OP_RST_FIRE);
    check("fire ignored", 48'h1, pulses);
    print_verdict();
  end
endmodule
`default_nettype wire
